// ==== rtl/mre_defines.vh ====
`ifndef MRE_DEFINES_VH
`define MRE_DEFINES_VH
// ==========================================
// Register byte offsets
`define MRE_CTRL_OFS 12'h000
`define MRE_STAT_OFS 12'h004
`define MRE_IRQ_STAT_OFS 12'h008
`define MRE_IRQ_MASK_OFS 12'h00C
`define MRE_OVR_MIN_OFS 12'h010
`define MRE_OVR_TOT_OFS 12'h014
`define MRE_OVR_CNT_OFS 12'h018
// ==========================================
// Control fields
`define MRE_CTRL_RUN 0
`define MRE_CTRL_OVR_EN 1
// Status fields
`define MRE_STAT_ERR 0
`define MRE_STAT_REL 1
`define MRE_STAT_OREQ 2
`define MRE_STAT_MUTE 3
`define MRE_STAT_OVR 4
`define MRE_STAT_BLK 5
// Interrupt fields
`define MRE_IRQ_ERR 0
`define MRE_IRQ_OREQ 1
`define MRE_IRQ_OVR 2
`define MRE_IRQ_RUN 3
`define MRE_IRQ_W 4
// ==========================================
// Reset values
`define MRE_CTRL_RST 32'h0000_0002
`define MRE_OVR_MIN_RST 32'h004C_4B40
`define MRE_OVR_TOT_RST 32'h0EE6_B280
// ==========================================
// Timing: 50 MHz clock
`define MRE_CLK_HZ 50000000
`define MRE_OVR_MAX_S 3
`define MRE_OVR_MAX_CYC (`MRE_OVR_MAX_S * `MRE_CLK_HZ)
`define MRE_BLINK_HZ 2
`define MRE_BLINK_HALF_CYC (`MRE_CLK_HZ / (2 * `MRE_BLINK_HZ))
`endif

// ==== rtl/mre_muting_release.v ====
// The address map and register access over APB were decided locally.
`include "mre_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module mre_muting_release #(
	parameter [31:0] OVR_MAX_CYC = `MRE_OVR_MAX_CYC,
	parameter [31:0] BLINK_HALF_CYC = `MRE_BLINK_HALF_CYC
) (
	input wire clk,
	input wire rst_b,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [3:0] muting_sensor,
	input wire protective_device_switch_output,
	input wire override_in,
	input wire muting_fault,
	output reg release_out,
	output reg muting_error,
	output reg error_flag,
	output reg override_required,
	output wire irq
);
	// ==========================================
	// States
	localparam [2:0] ST_STOP = 3'd0;
	localparam [2:0] ST_IDLE = 3'd1;
	localparam [2:0] ST_MUTE = 3'd2;
	localparam [2:0] ST_DRAIN = 3'd3;
	localparam [2:0] ST_BLOCK = 3'd4;
	localparam [2:0] ST_OREQ = 3'd5;
	localparam [2:0] ST_OVR = 3'd6;
	localparam [2:0] ST_ERR = 3'd7;

	function any_high;
		input [3:0] s;
		begin
			any_high = |s;
		end
	endfunction

	// ==========================================
	// Registers
	reg [31:0] ctrl;
	reg [31:0] ovr_min;
	reg [31:0] ovr_tot;
	reg [`MRE_IRQ_W-1:0] irq_stat;
	reg [`MRE_IRQ_W-1:0] irq_mask;
	reg [15:0] ovr_cnt;
	reg [2:0] state;
	reg [2:0] next_state;
	reg [31:0] pulse_cnt;
	reg [31:0] tot_cnt;
	reg [31:0] blink_cnt;
	reg blink;
	reg ovr_d;
	reg run_d;
	reg [3:0] sens_d;
	wire wr_en = psel & penable & pwrite;
	wire run = ctrl[`MRE_CTRL_RUN];
	wire ovr_en = ctrl[`MRE_CTRL_OVR_EN];
	wire pdso = protective_device_switch_output;
	wire sens_any = any_high(muting_sensor);
	wire sens_full = &muting_sensor[1:0] | &muting_sensor[3:2];
	wire run_start = run & ~run_d;
	// Pulse accepted on falling edge only if width in [min, 3 s]
	wire ovr_fall = ovr_d & ~override_in;
	wire ovr_valid = ovr_fall & (pulse_cnt >= ovr_min) & (pulse_cnt <= OVR_MAX_CYC);
	// A correct sequence starts with one pair fully active from a clear field
	wire seq_start = ~any_high(sens_d) & sens_full;
	reg [`MRE_IRQ_W-1:0] ev;

	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign irq = |(irq_stat & irq_mask);

	// ==========================================
	// Sequence state
	always @* begin
		next_state = state;
		case (state)
			ST_STOP: begin
				if (run_start) begin
					if (pdso & ~sens_any)
						next_state = ST_IDLE;
					else if (pdso)
						next_state = ST_DRAIN;
					else if (~sens_any)
						next_state = ST_BLOCK;
					else
						next_state = ovr_en ? ST_OREQ : ST_ERR;
				end
			end
			ST_IDLE: begin
				if (muting_fault)
					next_state = ST_ERR;
				else if (seq_start)
					next_state = ST_MUTE;
			end
			ST_MUTE: begin
				if (muting_fault)
					next_state = ST_ERR;
				else if (~sens_any)
					next_state = ST_IDLE;
			end
			ST_DRAIN: begin
				if (~sens_any)
					next_state = ST_IDLE;
				else if (~pdso)
					next_state = ovr_en ? ST_OREQ : ST_ERR;
			end
			ST_BLOCK: begin
				if (pdso)
					next_state = ST_IDLE;
			end
			ST_OREQ: begin
				if (ovr_valid)
					next_state = ST_OVR;
				else if (seq_start)
					next_state = ST_MUTE;
				else if (~sens_any & pdso)
					next_state = ST_IDLE;
			end
			ST_OVR: begin
				if (~sens_any)
					next_state = ST_IDLE;
				else if (tot_cnt >= ovr_tot)
					next_state = ST_ERR;
			end
			ST_ERR: begin
				if (~sens_any & pdso & ~muting_fault)
					next_state = ST_IDLE;
				else if (ovr_en & ovr_valid)
					next_state = ST_OVR;
			end
			default: next_state = ST_STOP;
		endcase
		if (~run)
			next_state = ST_STOP;
	end

	always @* begin
		ev = {`MRE_IRQ_W{1'b0}};
		ev[`MRE_IRQ_ERR] = (next_state == ST_ERR) & (state != ST_ERR);
		ev[`MRE_IRQ_OREQ] = (next_state == ST_OREQ) & (state != ST_OREQ);
		ev[`MRE_IRQ_OVR] = (next_state == ST_OVR) & (state != ST_OVR);
		ev[`MRE_IRQ_RUN] = run_start;
	end

	// ==========================================
	// Clocked logic, re-evaluated every cycle
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_STOP;
			run_d <= 1'b0;
			ovr_d <= 1'b0;
			sens_d <= 4'h0;
			pulse_cnt <= 32'h0000_0000;
			tot_cnt <= 32'h0000_0000;
			blink_cnt <= 32'h0000_0000;
			blink <= 1'b0;
			ovr_cnt <= 16'h0000;
			release_out <= 1'b0;
			muting_error <= 1'b0;
			error_flag <= 1'b0;
			override_required <= 1'b0;
		end else begin
			state <= next_state;
			run_d <= run;
			ovr_d <= override_in;
			sens_d <= muting_sensor;
			// Saturate so an overlong pulse stays out of range
			if (override_in) begin
				if (pulse_cnt != 32'hFFFF_FFFF)
					pulse_cnt <= pulse_cnt + 32'h0000_0001;
			end else begin
				pulse_cnt <= 32'h0000_0000;
			end
			if (next_state == ST_OVR && state == ST_OVR)
				tot_cnt <= tot_cnt + 32'h0000_0001;
			else
				tot_cnt <= 32'h0000_0000;
			if (state == ST_OREQ) begin
				if (blink_cnt >= BLINK_HALF_CYC - 32'h0000_0001) begin
					blink_cnt <= 32'h0000_0000;
					blink <= ~blink;
				end else begin
					blink_cnt <= blink_cnt + 32'h0000_0001;
				end
			end else begin
				blink_cnt <= 32'h0000_0000;
				blink <= 1'b1;
			end
			// Count override requests; clear after a valid muting cycle
			// A request raised by the run start itself is the first one counted
			if (run_start)
				ovr_cnt <= ev[`MRE_IRQ_OREQ] ? 16'h0001 : 16'h0000;
			else if (state == ST_MUTE && next_state == ST_IDLE)
				ovr_cnt <= 16'h0000;
			else if (ev[`MRE_IRQ_OREQ])
				ovr_cnt <= ovr_cnt + 16'h0001;
			muting_error <= (next_state == ST_ERR);
			error_flag <= (next_state == ST_ERR);
			override_required <= (next_state == ST_OREQ) & (state == ST_OREQ ? blink : 1'b1);
			// Release needs no error and a reason to pass
			release_out <= (next_state != ST_ERR) && (next_state != ST_STOP) &&
				((next_state == ST_MUTE) || (next_state == ST_OVR) || pdso);
		end
	end

	// ==========================================
	// APB slave, zero wait states
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl <= `MRE_CTRL_RST;
			ovr_min <= `MRE_OVR_MIN_RST;
			ovr_tot <= `MRE_OVR_TOT_RST;
			irq_stat <= {`MRE_IRQ_W{1'b0}};
			irq_mask <= {`MRE_IRQ_W{1'b0}};
		end else begin
			// New events win over a simultaneous write-one clear
			if (wr_en && paddr == `MRE_IRQ_STAT_OFS)
				irq_stat <= (irq_stat & ~pwdata[`MRE_IRQ_W-1:0]) | ev;
			else
				irq_stat <= irq_stat | ev;
			if (wr_en) begin
				case (paddr)
					`MRE_CTRL_OFS: ctrl <= {30'h0000_0000, pwdata[1:0]};
					`MRE_IRQ_MASK_OFS: irq_mask <= pwdata[`MRE_IRQ_W-1:0];
					`MRE_OVR_MIN_OFS: ovr_min <= pwdata;
					`MRE_OVR_TOT_OFS: ovr_tot <= pwdata;
					default: ;
				endcase
			end
		end
	end

	always @* begin
		case (paddr)
			`MRE_CTRL_OFS: prdata = ctrl;
			`MRE_STAT_OFS: prdata = {26'h000_0000, state == ST_BLOCK, state == ST_OVR, state == ST_MUTE,
				override_required, release_out, muting_error};
			`MRE_IRQ_STAT_OFS: prdata = {28'h000_0000, irq_stat};
			`MRE_IRQ_MASK_OFS: prdata = {28'h000_0000, irq_mask};
			`MRE_OVR_MIN_OFS: prdata = ovr_min;
			`MRE_OVR_TOT_OFS: prdata = ovr_tot;
			`MRE_OVR_CNT_OFS: prdata = {16'h0000, ovr_cnt};
			default: prdata = 32'h0000_0000;
		endcase
	end
endmodule // mre_muting_release
`default_nettype wire

// ==== test/mre_chk_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module mre_chk (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic [3:0] muting_sensor,
	input wire logic protective_device_switch_output,
	input wire logic override_in,
	input wire logic muting_fault,
	input wire logic release_out,
	input wire logic muting_error,
	input wire logic error_flag,
	input wire logic override_required
);
	wire logic pd = protective_device_switch_output;
	wire logic [3:0] ms = muting_sensor;
	wire logic ov = override_in;
	wire logic orq = override_required;
	wire logic bus = psel;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ==========
	// Output relations
	// The fault, sticky and blink checks exclude bus cycles because a stop write may legally end any state
	a_err_no_rel: assert property (muting_error |-> !release_out)
		else $error("release in error");
	a_flag_same: assert property (error_flag == muting_error)
		else $error("flag differs");
	a_rel_cause: assert property (release_out |-> $past(pd) || $past(ms) != 4'h0)
		else $error("release without cause");
	a_fault_err: assert property (!bus && !$past(bus) && muting_fault && release_out
		&& ms == 4'h0 && $past(ms) == 4'h0 |=> muting_error) else $error("fault missed");
	a_err_sticky: assert property (!bus && !$past(bus) && muting_error && (ms != 4'h0 || !pd)
		&& !ov && !$past(ov) && !$past(ov, 2) |=> muting_error) else $error("error left early");
	a_oreq_no_rel: assert property (orq |-> !release_out)
		else $error("release while requesting");
	a_blink_hold: assert property (!bus && $rose(orq) && !ov && !$past(ov) |-> orq [*3])
		else $error("blink too short");
	a_blink_low: assert property (!bus && $fell(orq) && !ov |-> !orq [*3])
		else $error("blink gap too short");
	c_error: cover property ($rose(muting_error));
	c_release: cover property ($rose(release_out));
	c_request: cover property ($rose(orq));
endmodule // mre_chk
bind mre_muting_release mre_chk chk (.*);
`default_nettype wire

// ==== test/mre_field_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mre_field_model (
	input wire logic clk,
	input wire logic [3:0] sens_cmd,
	input wire logic pdso_cmd,
	input wire logic ovr_cmd,
	input wire logic fault_cmd,
	output var logic [3:0] muting_sensor = 4'h0,
	output var logic protective_device_switch_output = 1'h0,
	output var logic override_in = 1'h0,
	output var logic muting_fault = 1'h0
);
	// ==========
	// Field response
	// One cycle of lag, like input filtering, so nothing moves on the edge the bench drives
	always @(posedge clk) begin
		{muting_sensor, protective_device_switch_output, override_in, muting_fault}
			<= {sens_cmd, pdso_cmd, ovr_cmd, fault_cmd};
	end
endmodule // mre_field_model
`default_nettype wire

// ==== test/mre_muting_release_tb.sv ====
`include "mre_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module mre_muting_release_tb;
	logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pdso_cmd = 0, ovr_cmd = 0, fault_cmd = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic [3:0] sens_cmd = 4'h0, muting_sensor;
	logic pready, pslverr, protective_device_switch_output, override_in, muting_fault;
	logic release_out, muting_error, error_flag, override_required, irq;
	int errors = 0, samples_checked = 0;
	mre_field_model fm (.*);
	mre_muting_release #(.OVR_MAX_CYC(32'h0000_00C8), .BLINK_HALF_CYC(32'h0000_0004)) uut (.*);
	always #10 clk = ~clk;
	// ==========
	// Tasks
	task w(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, pwrite, paddr, pwdata} <= {1'h1, wr, a, d};
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1) @(posedge clk);
		q = prdata;
		{psel, penable} <= 2'h0;
		@(negedge clk);
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) errors++;
		if (got !== exp) $display("BAD %0t got %h want %h", $time, got, exp);
	endtask
	task fld(input logic [3:0] s, input logic p, input logic o, input logic f, input int n);
		@(posedge clk);
		{sens_cmd, pdso_cmd, ovr_cmd, fault_cmd} <= {s, p, o, f};
		w(n);
	endtask
	task complete_run;
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (4000) @(posedge clk);
		errors++;
		complete_run();
	end
	// ==========
	// Scenarios
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'h1;
		apb(1'h0, 12'h000, 32'h0000_0000);
		chk(q, `MRE_CTRL_RST);
		apb(1'h0, 12'h020, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		apb(1'h1, 12'h010, 32'h0000_0003);
		apb(1'h1, 12'h00C, 32'h0000_000E);
		fld(4'h0, 1'h1, 1'h0, 1'h0, 2);
		apb(1'h1, 12'h000, 32'h0000_0003);
		w(1);
		chk({release_out, irq}, 2'h3);
		apb(1'h1, 12'h008, 32'h0000_0008);
		chk(irq, 1'h0);
		fld(4'h3, 1'h1, 1'h0, 1'h0, 2);
		fld(4'h3, 1'h0, 1'h0, 1'h0, 4);
		chk(release_out, 1'h1);
		fld(4'h3, 1'h1, 1'h0, 1'h0, 2);
		fld(4'h0, 1'h1, 1'h0, 1'h0, 4);
		chk(release_out, 1'h1);
		fld(4'h0, 1'h1, 1'h0, 1'h1, 4);
		chk({muting_error, error_flag, release_out, irq}, 4'hC);
		apb(1'h1, 12'h00C, 32'h0000_000F);
		chk(irq, 1'h1);
		fld(4'h3, 1'h1, 1'h0, 1'h0, 4);
		chk(muting_error, 1'h1);
		fld(4'h0, 1'h1, 1'h0, 1'h0, 4);
		chk({muting_error, release_out}, 2'h1);
		apb(1'h1, 12'h000, 32'h0000_0002);
		fld(4'h1, 1'h0, 1'h0, 1'h0, 2);
		apb(1'h1, 12'h000, 32'h0000_0003);
		w(1);
		chk({override_required, release_out}, 2'h2);
		fld(4'h1, 1'h0, 1'h1, 1'h0, 1);
		fld(4'h1, 1'h0, 1'h0, 1'h0, 6);
		chk(release_out, 1'h0);
		fld(4'h1, 1'h0, 1'h1, 1'h0, 4);
		fld(4'h1, 1'h0, 1'h0, 1'h0, 4);
		chk(release_out, 1'h1);
		apb(1'h0, 12'h018, 32'h0000_0000);
		chk(q, 32'h0000_0001);
		apb(1'h1, 12'h000, 32'h0000_0002);
		fld(4'h0, 1'h0, 1'h0, 1'h0, 2);
		apb(1'h1, 12'h000, 32'h0000_0003);
		w(4);
		chk(release_out, 1'h0);
		fld(4'h0, 1'h1, 1'h0, 1'h0, 4);
		chk(release_out, 1'h1);
		complete_run();
	end
endmodule // mre_muting_release_tb
`default_nettype wire
